// ---- rtl/status_led_mode_select.sv ----
// Purpose: Network indicator LEDs, host interface mode decode and core clock select
// Assumes: All inputs synchronous to clock; link status comes from the PHY core
// Notes:   LED outputs are active low and registered
`timescale 1ns/100ps

// Overview of operation
// - Link LED low while link up, high while down, any host mode.
// - Speed LED low at 100Mbps, high at 10Mbps.
// - Duplex LED low at full duplex, high at half duplex.
// - Activity LED steady low idle, toggles with traffic, high when link down.
// - Collision LED low on transmit collision while link up, high otherwise.
// - Straps 0000 pick serial host mode; 010X pick parallel, low bit ignored.
// - Core clock from 100MHz source: 25MHz low frequency or 100MHz normal.
module status_led_mode_select
#(
  parameter int ACT_FLASH_COUNT = status_led_pkg::ACT_FLASH_CYCLES
)
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // Link status from PHY core
  input  wire status_led_pkg::link_status_t link_status,
  // Board straps and clock mode
  input  wire logic [3:0]                   host_if_select,
  input  wire logic                         low_freq_mode,
  // Indicator LEDs
  output logic                              link_up_led_n,
  output logic                              speed_led_n,
  output logic                              duplex_led_n,
  output logic                              activity_led_n,
  output logic                              collision_led_n,
  // Decoded mode and core clock divider
  output status_led_pkg::host_if_t          host_if_mode,
  output logic [2:0]                        core_clk_div
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic status_led_pkg::host_if_t decode_mode(input logic [3:0] pat);
    if (pat == status_led_pkg::MODE_SERIAL_PAT)
      return status_led_pkg::HOST_IF_SERIAL;
    else if ((pat & status_led_pkg::MODE_PARALLEL_MSK) == status_led_pkg::MODE_PARALLEL_PAT)
      return status_led_pkg::HOST_IF_PARALLEL;
    else
      return status_led_pkg::HOST_IF_INVALID;
  endfunction

  logic [19:0] act_cnt_r;
  logic        act_tick;
  logic        act_phase_r;

  // ==========================================================================
  // Static indicators
  // ==========================================================================
  // Link, speed, duplex follow status directly
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      link_up_led_n <= 1'b1;
      speed_led_n   <= 1'b1;
      duplex_led_n  <= 1'b1;
    end
    else
    begin
      link_up_led_n <= ~link_status.link_up;
      speed_led_n   <= ~link_status.speed_100;
      duplex_led_n  <= ~link_status.full_duplex;
    end
  end

  // Collision only meaningful while transmitting on a live link
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      collision_led_n <= 1'b1;
    else
      collision_led_n <= ~(link_status.tx_collision & link_status.link_up);
  end

  // ==========================================================================
  // Activity flasher
  // ==========================================================================
  // Flash rate divider, runs only during traffic
  always_ff @(posedge clock)
  begin
    if (sys_rst || !link_status.traffic || !link_status.link_up)
      act_cnt_r <= status_led_pkg::ACT_CNT_RESET;
    else if (act_tick)
      act_cnt_r <= status_led_pkg::ACT_CNT_RESET;
    else
      act_cnt_r <= act_cnt_r + 20'h00001;
  end

  assign act_tick = (act_cnt_r == 20'(ACT_FLASH_COUNT - 1));

  // Phase toggles each tick; returns low when idle
  always_ff @(posedge clock)
  begin
    if (sys_rst || !link_status.link_up || !link_status.traffic)
      act_phase_r <= 1'b0;
    else if (act_tick)
      act_phase_r <= ~act_phase_r;
  end

  // Steady low idle, flashing with traffic, high when down
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      activity_led_n <= 1'b1;
    else if (!link_status.link_up)
      activity_led_n <= 1'b1;
    else
      activity_led_n <= act_phase_r;
  end

  // ==========================================================================
  // Mode decode and core clock select
  // ==========================================================================
  // Straps sampled continuously
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      host_if_mode <= status_led_pkg::HOST_IF_INVALID;
    else
      host_if_mode <= decode_mode(host_if_select);
  end

  // Divider for 100 MHz core PLL: bypass or divide by four
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      core_clk_div <= status_led_pkg::CORE_DIV_NORMAL;
    else if (low_freq_mode)
      core_clk_div <= status_led_pkg::CORE_DIV_LOW;
    else
      core_clk_div <= status_led_pkg::CORE_DIV_NORMAL;
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_link;
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> (link_up_led_n == !$past(link_status.link_up));
  endproperty
  a_link: assert property (p_link) else $error("link led wrong");

  property p_speed;
    @(posedge clock) disable iff (sys_rst)
    link_status.speed_100 |=> !speed_led_n;
  endproperty
  a_speed: assert property (p_speed) else $error("speed led wrong");

  property p_duplex;
    @(posedge clock) disable iff (sys_rst)
    !link_status.full_duplex |=> duplex_led_n;
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex led wrong");

  sequence s_idle_up;
    link_status.link_up && !link_status.traffic;
  endsequence

  property p_act_idle;
    @(posedge clock) disable iff (sys_rst)
    s_idle_up ##1 s_idle_up |=> !activity_led_n;
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("activity not steady low");

  property p_act_down;
    @(posedge clock) disable iff (sys_rst)
    !link_status.link_up |=> activity_led_n;
  endproperty
  a_act_down: assert property (p_act_down) else $error("activity not high on down");

  property p_col;
    @(posedge clock) disable iff (sys_rst)
    !link_status.tx_collision |=> collision_led_n;
  endproperty
  a_col: assert property (p_col) else $error("collision led wrong");

  property p_mode;
    @(posedge clock) disable iff (sys_rst)
    (host_if_select[3:1] == 3'h2) |=> (host_if_mode == status_led_pkg::HOST_IF_PARALLEL);
  endproperty
  a_mode: assert property (p_mode) else $error("parallel mode not decoded");

  property p_clk;
    @(posedge clock) disable iff (sys_rst)
    low_freq_mode |=> (core_clk_div == status_led_pkg::CORE_DIV_LOW);
  endproperty
  a_clk: assert property (p_clk) else $error("core clock select wrong");

  // Collision on a live link lights the LED one edge later
  property p_col_hit;
    @(posedge clock) disable iff (sys_rst)
    (link_status.tx_collision && link_status.link_up) |=> !collision_led_n;
  endproperty
  a_col_hit: assert property (p_col_hit) else $error("collision led not lit");

  // All-zero straps give serial host mode
  property p_mode_serial;
    @(posedge clock) disable iff (sys_rst)
    (host_if_select == status_led_pkg::MODE_SERIAL_PAT)
      |=> (host_if_mode == status_led_pkg::HOST_IF_SERIAL);
  endproperty
  a_mode_serial: assert property (p_mode_serial) else $error("serial mode wrong");

  // Any other strap pattern is reported as invalid
  property p_mode_bad;
    @(posedge clock) disable iff (sys_rst)
    (host_if_select[3] || host_if_select[1] || (host_if_select[0] && !host_if_select[2]))
      |=> (host_if_mode == status_led_pkg::HOST_IF_INVALID);
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("invalid straps not flagged");

  // Normal mode selects the undivided core clock
  property p_clk_normal;
    @(posedge clock) disable iff (sys_rst)
    !low_freq_mode |=> (core_clk_div == status_led_pkg::CORE_DIV_NORMAL);
  endproperty
  a_clk_normal: assert property (p_clk_normal) else $error("normal clock wrong");

  // Each flash tick during traffic shows as an LED change two edges on
  sequence s_busy_up;
    link_status.link_up && link_status.traffic;
  endsequence

  property p_act_flash;
    @(posedge clock) disable iff (sys_rst)
    (s_busy_up ##0 act_tick) ##1 s_busy_up |=> (activity_led_n != $past(activity_led_n));
  endproperty
  a_act_flash: assert property (p_act_flash) else $error("activity not flashing");

endmodule

// ---- rtl/status_led_pkg.sv ----
// Purpose: Shared constants and carrier types for the status LED and mode select block
// Assumes: 20 MHz system clock
// Notes:   Pin patterns and timing counts are named once here
package status_led_pkg;

  // ==========================================================================
  // Host interface mode straps
  // ==========================================================================
  localparam logic [3:0] MODE_SERIAL_PAT   = 4'h0;  // 0000
  localparam logic [3:0] MODE_PARALLEL_PAT = 4'h4;  // 010X
  localparam logic [3:0] MODE_PARALLEL_MSK = 4'he;  // Lowest bit ignored

  typedef enum logic [1:0]
  {
    HOST_IF_SERIAL,
    HOST_IF_PARALLEL,
    HOST_IF_INVALID
  } host_if_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ           = 20000000;
  localparam int ACT_FLASH_MS     = 50;          // Activity toggle half period
  localparam int ACT_FLASH_CYCLES = (CLK_HZ / 1000) * ACT_FLASH_MS;
  localparam logic [19:0] ACT_CNT_RESET = 20'h00000;

  // ==========================================================================
  // Core clock selection
  // ==========================================================================
  localparam logic [2:0] CORE_DIV_LOW    = 3'h3;  // 25 MHz from 100 MHz
  localparam logic [2:0] CORE_DIV_NORMAL = 3'h0;  // 100 MHz

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed
  {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic traffic;
    logic tx_collision;
  } link_status_t;

  typedef struct packed
  {
    logic link_n;
    logic speed_n;
    logic duplex_n;
    logic activity_n;
    logic collision_n;
  } led_bus_t;

endpackage

// ---- tb/led_board.sv ----
// Purpose: Board model: mode straps and LED watcher
// Assumes: LEDs active low
// Notes:   Counts activity LED edges
`timescale 1ns/100ps
module led_board
(
  // Clock and count clear
  input  wire logic       clock,
  input  wire logic       clr,
  // Strap choice and LED
  input  wire logic [3:0] strap_val,
  input  wire logic       activity_led_n,
  // Board side
  output logic [3:0]      host_if_select,
  output int              act_edges,
  // Host side, idle in this bench
  output logic            chip_select_n
);
  logic last_r;
  // Straps are wired levels
  assign host_if_select = strap_val;
  // No host access here, so chip select stays parked deselected
  assign chip_select_n = 1'b1;
  // Count activity LED changes
  always_ff @(posedge clock)
  begin
    last_r    <= activity_led_n;
    act_edges <= clr ? 0 : act_edges + int'(last_r != activity_led_n);
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for status LEDs and mode select
// Assumes: ACT_FLASH_COUNT of 4
// Notes:   Inputs change at falling edge
`timescale 1ns/100ps
module tb_top;
  logic                         clock = 1'b0;
  logic                         sys_rst = 1'b1;
  status_led_pkg::link_status_t link_status = 5'h1d;
  logic [3:0]                   strap_val = 4'h0;
  logic                         low_freq_mode = 1'b1;
  logic                         clr = 1'b1;
  logic [3:0]                   host_if_select;
  logic                         lnk, spd, dpx, act, col;
  status_led_pkg::host_if_t     host_if_mode;
  logic [2:0]                   core_clk_div;
  int                           act_edges;
  int                           fails = 0;
  int                           samples_checked = 0;
  int                           cycles = 0;
  // ==========================================================================
  // Design and board
  // ==========================================================================
  status_led_mode_select #(.ACT_FLASH_COUNT(4)) dut (.clock(clock), .sys_rst(sys_rst),
    .link_status(link_status), .host_if_select(host_if_select),
    .low_freq_mode(low_freq_mode), .link_up_led_n(lnk), .speed_led_n(spd),
    .duplex_led_n(dpx), .activity_led_n(act), .collision_led_n(col),
    .host_if_mode(host_if_mode), .core_clk_div(core_clk_div));
  led_board board (.clock(clock), .clr(clr), .strap_val(strap_val),
    .activity_led_n(act), .host_if_select(host_if_select), .act_edges(act_edges),
    .chip_select_n());
  // Clock and hang guard
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      finish_test();
    end
  end
  // ==========================================================================
  // Checks and scenarios
  // ==========================================================================
  task automatic chk_bit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_vec(string n, logic [2:0] e, logic [2:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic t_reset(int n);
    sys_rst = 1'b1;
    repeat (n) @(negedge clock);
    chk_vec("leds", 3'h7, {lnk, spd, dpx});
    chk_vec("leds2", 3'h3, {1'b0, act, col});
    chk_vec("mode", {1'b0, status_led_pkg::HOST_IF_INVALID}, {1'b0, host_if_mode});
    chk_vec("div", status_led_pkg::CORE_DIV_NORMAL, core_clk_div);
    sys_rst = 1'b0;
  endtask
  task automatic t_link();
    for (int i = 0; i < 16; i++)
    begin
      link_status = {i[3], i[2], i[1], 1'b0, i[0]};
      @(negedge clock);
      chk_bit("link", ~i[3], lnk);
      chk_bit("speed", ~i[2], spd);
      chk_bit("duplex", ~i[1], dpx);
      chk_bit("idle act", ~i[3], act);
      chk_bit("collision", ~(i[0] & i[3]), col);
    end
  endtask
  task automatic t_activity();
    link_status = 5'h10;
    repeat (6) @(negedge clock) chk_bit("steady act", 1'b0, act);
    clr = 1'b0;
    link_status = 5'h12;
    repeat (13) @(negedge clock);
    chk_bit("act toggles", 1'b1, act_edges == 2);
    chk_bit("act flash phase", 1'b1, act);
    link_status = 5'h10;
    repeat (2) @(negedge clock);
    chk_bit("act idle", 1'b0, act);
    link_status = 5'h02;
    repeat (8) @(negedge clock) chk_bit("act down", 1'b1, act);
  endtask
  task automatic t_modes();
    status_led_pkg::host_if_t e;
    for (int i = 0; i < 16; i++)
    begin
      strap_val = 4'(i);
      e = status_led_pkg::HOST_IF_INVALID;
      if (i == 0)
        e = status_led_pkg::HOST_IF_SERIAL;
      if ((i & 14) == 4)
        e = status_led_pkg::HOST_IF_PARALLEL;
      @(negedge clock);
      chk_vec("mode", {1'b0, e}, {1'b0, host_if_mode});
    end
  endtask
  task automatic t_clk();
    low_freq_mode = 1'b1;
    @(negedge clock);
    chk_vec("div low", status_led_pkg::CORE_DIV_LOW, core_clk_div);
    low_freq_mode = 1'b0;
    @(negedge clock);
    chk_vec("div normal", status_led_pkg::CORE_DIV_NORMAL, core_clk_div);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    t_reset(12);
    t_link();
    t_activity();
    t_modes();
    t_clk();
    t_reset(2);
    t_link();
    finish_test();
  end
endmodule
